// ### design/sba_pkg.sv
/*
 * Shared constants and types for the system bus arbiter and decoder
 * and for the bus master controller that drives it.
 * Assumes one 250 MHz clock for both ends.
 */
package sba_pkg;

    localparam int          NREQ          = 7;
    localparam int          CLK_NS        = 4;

    // requesters below this index sit on the system bus
    localparam logic [2:0]  SBUS_MASTERS  = 3'h3;

    // refresh guard: least wait before abort
    localparam int          TMO_NS        = 15000;
    localparam logic [11:0] TMO_CYC       = 12'((TMO_NS + CLK_NS - 1) / CLK_NS);

    // address decode on the upper 10 bits
    localparam logic [9:0]  DEC_ONB_END   = 10'h020;
    localparam logic [9:0]  DEC_EXP1_END  = 10'h040;
    localparam logic [9:0]  DEC_V32A_END  = 10'h200;
    localparam logic [9:0]  DEC_EXP2_END  = 10'h240;
    localparam logic [9:0]  DEC_V32B_END  = 10'h3F8;
    localparam logic [9:0]  DEC_V24_END   = 10'h3FC;
    localparam logic [9:0]  DEC_UTIL_BASE = 10'h3FF;
    localparam logic [15:0] DEC_V16_HI    = 16'hFF00;

    localparam logic [31:0] XTT_ADDR      = 32'hFFF88014;
    localparam logic [1:0]  WORD_ALIGN    = 2'h0;

    // modifier space bits
    localparam logic [1:0]  AM_SP_A32     = 2'h0;
    localparam logic [1:0]  AM_SP_A24     = 2'h3;
    localparam logic [1:0]  AM_SP_A16     = 2'h2;

    // transfer-type codes
    localparam logic [3:0]  XT_SUP_BLOCK  = 4'hF;
    localparam logic [3:0]  XT_SUP_PROG   = 4'hE;
    localparam logic [3:0]  XT_SUP_DATA   = 4'hD;
    localparam logic [3:0]  XT_USR_BLOCK  = 4'hB;
    localparam logic [3:0]  XT_USR_PROG   = 4'hA;
    localparam logic [3:0]  XT_USR_DATA   = 4'h9;

    typedef enum logic [2:0] {
        RG_ONBOARD, RG_EXPMEM, RG_UTIL, RG_VME32, RG_VME24, RG_VME16
    } sba_region_t;

    // controller register offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_ADDR      = 8'h04;
    localparam logic [7:0]  OFS_WDATA     = 8'h08;
    localparam logic [7:0]  OFS_STATUS    = 8'h0C;
    localparam logic [7:0]  OFS_RDATA     = 8'h10;
    localparam logic [7:0]  OFS_ISTAT     = 8'h14;
    localparam logic [7:0]  OFS_IMASK     = 8'h18;
    localparam logic [7:0]  OFS_HOLD      = 8'h1C;

    localparam int          CTRL_START    = 0;
    localparam int          CTRL_WRITE    = 1;
    localparam int          CTRL_WORD     = 2;
    localparam int          CTRL_ID_LO    = 4;
    localparam int          STAT_BUSY     = 0;
    localparam int          STAT_ERR      = 1;
    localparam int          STAT_GNT_LO   = 8;
    localparam int          EV_DONE       = 0;
    localparam int          EV_ERR        = 1;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// ### design/sba_if.sv
/*
 * Shared memory/system bus between the arbiter-decoder and the masters.
 * Assumes both ends share aclk; no signal has more than one driver.
 */
`timescale 1ns/10ps
interface sba_if;
    import sba_pkg::*;

    logic [NREQ-1:0] req;
    logic [NREQ-1:0] gnt;
    logic            cyc_valid;
    logic            cyc_write;
    logic            cyc_word;
    logic [31:0]     cyc_addr;
    logic [31:0]     cyc_wdata;
    logic            rsp_valid;
    logic            rsp_err;
    logic [31:0]     rsp_rdata;

    modport dev (
        input  req, cyc_valid, cyc_write, cyc_word, cyc_addr, cyc_wdata,
        output gnt, rsp_valid, rsp_err, rsp_rdata
    );
    modport ctl (
        output req, cyc_valid, cyc_write, cyc_word, cyc_addr, cyc_wdata,
        input  gnt, rsp_valid, rsp_err, rsp_rdata
    );
endinterface

// ### design/sba_bridge.sv
/*
 * Arbiter, address decoder and expansion-bus modifier generator.
 * Assumes masters hold req through a tenure and cyc_valid until rsp_valid.
 */
// Overview of operation
// R1 - one arbiter grants both buses together
// R2 - system-bus masters reach memory-bus targets only
// R3 - masters keep each tenure under 5 ms
// R4 - masters release one cycle between words/blocks
// R5 - abort over-long target wait with error
// R6 - strict fixed priority, no fairness
// R7 - order: network, SCSI, VME, caches 0/1
// R8 - system-bus transfers are aligned full words
// R9 - each address selects exactly one region
// R10 - decode upper 10 bits, A16 on 16
// R11 - drive address and modifier together
// R12 - modifier space bits from decoded space
// R13 - modifier low bits from transfer-type field
// R14 - six transfer-type codes, user means unprivileged
// R15 - transfer-type register survives every reset
// R16 - software loads transfer type before access
// R17 - re-arbitrate only after master releases
`timescale 1ns/10ps
module sba_bridge
    import sba_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    sba_if.dev               bus,
    output logic             tgt_valid,
    output sba_region_t      tgt_region,
    output logic [31:0]      tgt_addr,
    output logic             tgt_write,
    output logic             tgt_word,
    output logic [31:0]      tgt_wdata,
    input  wire logic        tgt_ready,
    input  wire logic        tgt_err,
    input  wire logic [31:0] tgt_rdata,
    output logic [31:0]      vme_addr,
    output logic [5:0]       vme_am,
    output logic             vme_as
);

    typedef enum logic [1:0] {DS_IDLE, DS_OWN, DS_TGT, DS_RESP} sba_dstate_t;

    typedef struct packed {
        sba_dstate_t     state;
        logic [NREQ-1:0] gnt;
        logic [2:0]      owner;
        logic [11:0]     tmo;
        logic            rsp_valid;
        logic            rsp_err;
        logic [31:0]     rsp_rdata;
        logic            tgt_valid;
        sba_region_t     tgt_region;
        logic [31:0]     tgt_addr;
        logic            tgt_write;
        logic            tgt_word;
        logic [31:0]     tgt_wdata;
        logic [31:0]     vme_addr;
        logic [5:0]      vme_am;
        logic            vme_as;
        logic [7:0]      xtt;
    } sba_dev_st_t;

    sba_dev_st_t q;
    sba_dev_st_t d;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // lowest index wins, index 0 is the network interface
    function automatic logic [2:0] pick_idx(input logic [NREQ-1:0] r);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = NREQ - 1; i >= 0; i--) begin
            if (r[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    function automatic sba_region_t decode(input logic [31:0] a);
        logic [9:0]  top;
        sba_region_t rg;
        top = a[31:22];
        if (top < DEC_ONB_END) begin
            rg = RG_ONBOARD;
        end else if (top < DEC_EXP1_END) begin
            rg = RG_EXPMEM;
        end else if (top < DEC_V32A_END) begin
            rg = RG_VME32;
        end else if (top < DEC_EXP2_END) begin
            rg = RG_EXPMEM;
        end else if (top < DEC_V32B_END) begin
            rg = RG_VME32;
        end else if (top < DEC_V24_END) begin
            rg = RG_VME24;
        end else if (top >= DEC_UTIL_BASE) begin
            rg = RG_UTIL;
        end else if (a[31:16] == DEC_V16_HI) begin
            rg = RG_VME16;
        end else begin
            rg = RG_UTIL;
        end
        return rg;
    endfunction

    function automatic logic [1:0] space_bits(input sba_region_t rg);
        logic [1:0] sp;
        unique case (rg)
            RG_VME24: sp = AM_SP_A24;
            RG_VME16: sp = AM_SP_A16;
            default:  sp = AM_SP_A32;
        endcase
        return sp;
    endfunction

    function automatic logic is_vme(input sba_region_t rg);
        return (rg == RG_VME32) || (rg == RG_VME24) || (rg == RG_VME16);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    sba_region_t rg;
    logic        sbus_mst;
    logic        sbus_tgt;
    logic        aligned;

    always_comb begin
        d         = q;
        rg        = decode(bus.cyc_addr); // R9
        sbus_mst  = q.owner < SBUS_MASTERS;
        sbus_tgt  = (rg != RG_ONBOARD) && (rg != RG_EXPMEM);
        aligned   = bus.cyc_word && (bus.cyc_addr[1:0] == WORD_ALIGN);
        d.rsp_valid = 1'b0;
        unique case (q.state)
            DS_IDLE: begin
                if (|bus.req) begin // R17
                    d.owner           = pick_idx(bus.req);                   // R6 R7
                    d.gnt             = '0;
                    d.gnt[d.owner]    = 1'b1;                                // R1
                    d.state           = DS_OWN;
                end
            end
            DS_OWN: begin
                if (!bus.req[q.owner]) begin // R17
                    d.gnt   = '0;
                    d.state = DS_IDLE;
                end else if (bus.cyc_valid) begin
                    d.state     = DS_RESP;
                    d.rsp_valid = 1'b1;
                    d.rsp_err   = 1'b0;
                    d.rsp_rdata = '0;
                    if (sbus_mst && sbus_tgt) begin // R2
                        d.rsp_err = 1'b1;
                    end else if ((sbus_mst || sbus_tgt) && !aligned) begin   // R8
                        d.rsp_err = 1'b1;
                    end else if (bus.cyc_addr == XTT_ADDR) begin
                        // write-only, reads return zero
                        if (bus.cyc_write) begin
                            d.xtt = bus.cyc_wdata[7:0]; // R13 R14
                        end
                    end else begin
                        d.rsp_valid  = 1'b0;
                        d.state      = DS_TGT;
                        d.tmo        = '0;
                        d.tgt_valid  = 1'b1;
                        d.tgt_region = rg;
                        d.tgt_addr   = bus.cyc_addr;
                        d.tgt_write  = bus.cyc_write;
                        d.tgt_word   = bus.cyc_word;
                        d.tgt_wdata  = bus.cyc_wdata;
                        if (is_vme(rg)) begin                                // R10
                            d.vme_addr = bus.cyc_addr; // R11
                            d.vme_am   = {space_bits(rg), q.xtt[3:0]};       // R12 R13
                            d.vme_as   = 1'b1; // R11
                        end
                    end
                end
            end
            DS_TGT: begin
                d.tmo = q.tmo + 12'h001;
                if (tgt_ready) begin
                    d.tgt_valid = 1'b0;
                    d.vme_as    = 1'b0;
                    d.rsp_valid = 1'b1;
                    d.rsp_err   = tgt_err;
                    d.rsp_rdata = tgt_rdata;
                    d.state     = DS_RESP;
                end else if (q.tmo == TMO_CYC - 12'h001) begin               // R5
                    d.tgt_valid = 1'b0;
                    d.vme_as    = 1'b0;
                    d.rsp_valid = 1'b1;
                    d.rsp_err   = 1'b1;
                    d.rsp_rdata = '0;
                    d.state     = DS_RESP;
                end
            end
            DS_RESP: begin
                // master drops cyc_valid on this edge
                d.state = DS_OWN;
            end
        endcase
        if (!aresetn) begin
            d     = sba_dev_st_t'('0);
            d.xtt = q.xtt; // R15
        end
    end

    always_ff @(posedge aclk) begin
        q <= d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign bus.gnt       = q.gnt;
    assign bus.rsp_valid = q.rsp_valid;
    assign bus.rsp_err   = q.rsp_err;
    assign bus.rsp_rdata = q.rsp_rdata;
    assign tgt_valid     = q.tgt_valid;
    assign tgt_region    = q.tgt_region;
    assign tgt_addr      = q.tgt_addr;
    assign tgt_write     = q.tgt_write;
    assign tgt_word      = q.tgt_word;
    assign tgt_wdata     = q.tgt_wdata;
    assign vme_addr      = q.vme_addr;
    assign vme_am        = q.vme_am;
    assign vme_as        = q.vme_as;

endmodule

// ### design/sba_master.sv
/*
 * Bus master controller: software starts single-word transfers and
 * holds raw request lines through an AXI4-Lite register slave.
 * Assumes the arbiter-decoder answers every cycle with rsp_valid.
 */
`timescale 1ns/10ps
module sba_master
    import sba_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    sba_if.ctl               bus,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             irq
);

    typedef enum logic [1:0] {CS_IDLE, CS_REQ, CS_CYC, CS_REL} sba_cstate_t;

    typedef struct packed {
        sba_cstate_t     state;
        logic            awready, wready, arready, bvalid, rvalid;
        logic [1:0]      bresp, rresp;
        logic [31:0]     rdata;
        logic            aw_have, w_have;
        logic [7:0]      awaddr;
        logic [31:0]     wdata;
        logic [3:0]      wstrb;
        logic [31:0]     cmd_addr, cmd_wdata, rd_data;
        logic [2:0]      cmd_id;
        logic            cmd_write, cmd_word, busy, last_err;
        logic [1:0]      sts, mask;
        logic [NREQ-1:0] hold, eng, req;
        logic            cyc_valid, cyc_write, cyc_word;
        logic [31:0]     cyc_addr, cyc_wdata;
        logic            irq;
    } sba_ctl_st_t;

    sba_ctl_st_t q;
    sba_ctl_st_t d;

    function automatic logic mapped(input logic [7:0] a);
        return a inside {OFS_CTRL, OFS_ADDR, OFS_WDATA, OFS_STATUS,
                         OFS_RDATA, OFS_ISTAT, OFS_IMASK, OFS_HOLD};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = n[8*b +: 8];
            end
        end
        return r;
    endfunction

    logic [1:0]  ev_set;
    logic [1:0]  ev_clr;
    logic [31:0] cw;

    always_comb begin
        d      = q;
        ev_set = '0;
        ev_clr = '0;
        cw     = merge('0, q.wdata, q.wstrb);
        ////////////////////////////////////////////////////////////////////////////
        // register slave
        if (s_axi_awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.awaddr  = s_axi_awaddr;
            d.awready = 1'b0;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.wdata  = s_axi_wdata;
            d.wstrb  = s_axi_wstrb;
            d.wready = 1'b0;
        end
        if (q.aw_have && q.w_have && !q.bvalid) begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = mapped(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (q.awaddr)
                OFS_CTRL: begin
                    // start ignored unless idle
                    if (cw[CTRL_START] && q.state == CS_IDLE) begin
                        d.cmd_write = cw[CTRL_WRITE];
                        d.cmd_word  = cw[CTRL_WORD];
                        d.cmd_id    = cw[CTRL_ID_LO +: 3];
                        d.busy      = 1'b1;
                        d.state     = CS_REQ;
                    end
                end
                OFS_ADDR:  d.cmd_addr  = merge(q.cmd_addr, q.wdata, q.wstrb);
                OFS_WDATA: d.cmd_wdata = merge(q.cmd_wdata, q.wdata, q.wstrb);
                OFS_ISTAT: ev_clr      = cw[1:0];
                OFS_IMASK: d.mask      = cw[1:0];
                OFS_HOLD:  d.hold      = cw[NREQ-1:0];
                default: begin
                end
            endcase
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid  = 1'b0;
            d.awready = 1'b1;
            d.wready  = 1'b1;
        end
        if (s_axi_arvalid && q.arready) begin
            d.arready = 1'b0;
            d.rvalid  = 1'b1;
            d.rresp   = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            d.rdata   = '0;
            unique case (s_axi_araddr)
                OFS_CTRL: begin
                    d.rdata[CTRL_WRITE]      = q.cmd_write;
                    d.rdata[CTRL_WORD]       = q.cmd_word;
                    d.rdata[CTRL_ID_LO +: 3] = q.cmd_id;
                end
                OFS_ADDR:  d.rdata = q.cmd_addr;
                OFS_WDATA: d.rdata = q.cmd_wdata;
                OFS_STATUS: begin
                    d.rdata[STAT_BUSY]            = q.busy;
                    d.rdata[STAT_ERR]             = q.last_err;
                    d.rdata[STAT_GNT_LO +: NREQ]  = bus.gnt;
                end
                OFS_RDATA: d.rdata       = q.rd_data;
                OFS_ISTAT: d.rdata[1:0]  = q.sts;
                OFS_IMASK: d.rdata[1:0]  = q.mask;
                OFS_HOLD:  d.rdata[NREQ-1:0] = q.hold;
                default: begin
                end
            endcase
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid  = 1'b0;
            d.arready = 1'b1;
        end
        ////////////////////////////////////////////////////////////////////////////
        // transfer engine: one word per tenure
        unique case (q.state)
            CS_IDLE: begin
            end
            CS_REQ: begin
                d.eng            = '0;
                d.eng[q.cmd_id]  = 1'b1;
                if (bus.gnt[q.cmd_id]) begin
                    d.cyc_valid = 1'b1;
                    d.cyc_write = q.cmd_write;
                    d.cyc_word  = q.cmd_word;
                    d.cyc_addr  = q.cmd_addr;
                    d.cyc_wdata = q.cmd_wdata;
                    d.state     = CS_CYC;
                end
            end
            CS_CYC: begin
                if (bus.rsp_valid) begin
                    d.cyc_valid  = 1'b0;
                    d.eng        = '0; // R3 R4
                    d.rd_data    = bus.rsp_rdata;
                    d.last_err   = bus.rsp_err;
                    d.busy       = 1'b0;
                    ev_set[EV_DONE] = 1'b1;
                    ev_set[EV_ERR]  = bus.rsp_err;
                    d.state      = CS_REL;
                end
            end
            CS_REL: begin
                // one released cycle before the next start
                d.state = CS_IDLE; // R4
            end
        endcase
        d.req = d.hold | d.eng;
        d.sts = (q.sts & ~ev_clr) | ev_set;
        d.irq = |(d.sts & d.mask);
        if (!aresetn) begin
            d         = sba_ctl_st_t'('0);
            d.awready = 1'b1;
            d.wready  = 1'b1;
            d.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        q <= d;
    end

    assign bus.req       = q.req;
    assign bus.cyc_valid = q.cyc_valid;
    assign bus.cyc_write = q.cyc_write;
    assign bus.cyc_word  = q.cyc_word;
    assign bus.cyc_addr  = q.cyc_addr;
    assign bus.cyc_wdata = q.cyc_wdata;
    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign irq           = q.irq;

endmodule

// ### dv/sba_asserts.sv
/* bus checker for the arbiter-decoder and the master
   assumes one clock and a synchronous active-low reset */
`timescale 1ns/10ps
module sba_asserts
    import sba_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [6:0]  req,
    input wire logic [6:0]  gnt,
    input wire logic        cyc_valid,
    input wire logic        cyc_word,
    input wire logic [31:0] cyc_addr,
    input wire logic        rsp_valid,
    input wire logic        rsp_err
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [11:0] wait_q;
    wire         far = cyc_addr[31:22] >= DEC_EXP2_END
                       || (cyc_addr[31:22] >= DEC_EXP1_END && cyc_addr[31:22] < DEC_V32A_END);
    wire         ok  = rsp_valid && !rsp_err;
    always_ff @(posedge aclk) begin
        wait_q <= (!aresetn || !cyc_valid || rsp_valid) ? 12'h0 : wait_q + 12'h1;
    end
    chk_gnt_onehot: assert property ($onehot0(gnt))
        else $error("grant not one-hot");
    chk_gnt_prio:
        assert property ($rose(|gnt) |-> gnt == ($past(req) & (~$past(req) + 7'h1)))
        else $error("grant not to top requester");
    chk_keep_owner: assert property (|(gnt & req) |=> gnt == $past(gnt))
        else $error("grant moved in tenure");
    chk_release: assert property (gnt != 7'h0 && !(|(gnt & req)) |=> gnt == 7'h0)
        else $error("grant kept after release");
    chk_rsp_owner: assert property (rsp_valid |-> cyc_valid && gnt != 7'h0)
        else $error("response outside tenure");
    chk_sbus_word: assert property (ok && (|gnt[2:0] || far) |-> cyc_word && !(|cyc_addr[1:0]))
        else $error("unaligned transfer accepted");
    chk_sbus_route: assert property (ok && |gnt[2:0] |-> !far)
        else $error("system master reached system target");
    chk_wait_bound: assert property (wait_q < 12'hEB0)
        else $error("bus wait not aborted");
endmodule

// ### dv/tb.sv
/* bench joining master and arbiter-decoder; plays targets and host
   assumes a 250 MHz clock and the package register offsets */
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch %0t got %h exp %h", $time, a, e); end end
module tb;
    import sba_pkg::*;
    logic        aclk = 1'h0, aresetn = 1'h0, stall = 1'h0, terr = 1'h0, e;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, tgt_ready = 1'h0, tgt_err = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic        tgt_valid, tgt_write, tgt_word, vme_as;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [3:0]  code [6] = '{4'hF, 4'hE, 4'hD, 4'hB, 4'hA, 4'h9};
    logic [5:0]  vme_am;
    logic [6:0]  v;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, tgt_rdata = 32'h0, s_axi_rdata, tgt_addr, tgt_wdata;
    logic [31:0] vme_addr, cur_a, rd, xtt_m;
    logic [33:0] cur_x;
    logic [31:0] base [5] = '{32'h2000_0000, 32'hFE00_0000, 32'hFF00_0000, 32'h0, 32'hFFC0_0000};
    logic [31:0] msk [5] = '{32'h03FF_FFFC, 32'hFF_FFFC, 32'hFFFC, 32'h07FF_FFFF, 32'hFFFF};
    sba_region_t tgt_region;
    int          mismatches = 0, compares = 0;
    sba_if       bus ();
    sba_master   sba_master_inst (.*);
    sba_bridge   sba_bridge_inst (.*);
    sba_asserts  sba_asserts_inst (.aclk, .aresetn, .req(bus.req), .gnt(bus.gnt),
        .cyc_valid(bus.cyc_valid), .cyc_word(bus.cyc_word), .cyc_addr(bus.cyc_addr),
        .rsp_valid(bus.rsp_valid), .rsp_err(bus.rsp_err));
    always #2 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic sba_region_t rg(input logic [31:0] a);
        logic [9:0] t;
        t = a[31:22];
        if (t < 10'h20) return RG_ONBOARD;
        if (t < 10'h40 || (t >= 10'h200 && t < 10'h240)) return RG_EXPMEM;
        if (t < 10'h3F8) return RG_VME32;
        if (t < 10'h3FC) return RG_VME24;
        return (t != 10'h3FF && a[31:16] == 16'hFF00) ? RG_VME16 : RG_UTIL;
    endfunction
    // target side: one-cycle ready unless stalled
    always @(posedge aclk) begin
        tgt_ready <= tgt_valid && !tgt_ready && !stall;
        tgt_err <= terr;
        tgt_rdata <= tgt_valid ? {tgt_addr[15:0], tgt_addr[31:16]} : ~tgt_rdata;
        if (tgt_valid && tgt_ready) begin
            `CHK(tgt_addr, cur_a)
            `CHK({tgt_write, tgt_word, tgt_wdata}, cur_x)
            `CHK(tgt_region, rg(cur_a))
            `CHK(vme_as, rg(cur_a) > RG_UTIL)
            if (rg(cur_a) > RG_UTIL) begin
                `CHK(vme_addr, cur_a)
                `CHK(vme_am, {rg(cur_a) != RG_VME32, rg(cur_a) == RG_VME24, xtt_m[3:0]})
            end
        end
    end
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        `CHK(s_axi_bresp, a > OFS_HOLD ? RESP_SLVERR : RESP_OKAY)
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        d = s_axi_rdata;
        `CHK(s_axi_rresp, a > OFS_HOLD ? RESP_SLVERR : RESP_OKAY)
    endtask
    task automatic op(input logic [2:0] id, input logic wr, wd, input logic [31:0] a, d);
        logic [31:0] s;
        logic        sb;
        logic        far;
        cur_a = a;
        cur_x = {wr, wd, d};
        axw(OFS_ADDR, a);
        axw(OFS_WDATA, d);
        axw(OFS_CTRL, {25'h0, id, 1'h0, wd, wr, 1'h1});
        sb = id < 3'h3;
        far = rg(a) >= RG_UTIL;
        e = (sb && far) || ((sb || far) && !(wd && a[1:0] == 2'h0)) || stall || terr;
        s = 32'h1;
        while (s[STAT_BUSY]) axr(OFS_STATUS, s);
        axr(OFS_RDATA, rd);
        `CHK(s[STAT_ERR], e)
        if (!wr && !e) `CHK(rd, a == XTT_ADDR ? 32'h0 : {a[15:0], a[31:16]})
        if (wr && !e && a == XTT_ADDR) xtt_m = d;
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hD96988B4));
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 6; i++) begin
            op(3'h3 + i[1:0], 1'h1, 1'h1, XTT_ADDR, ($urandom() & 32'hF0) | code[i]);
            for (int j = 0; j < 5; j++)
                op(3'($urandom_range(0, 6)), 1'($urandom()), j < 3 || 1'($urandom()),
                   base[j] | ($urandom() & msk[j]), $urandom());
        end
        repeat (6) begin
            v = 7'($urandom_range(1, 127));
            axw(OFS_HOLD, {25'h0, v});
            axr(OFS_STATUS, rd);
            `CHK(rd[14:8], v & (~v + 7'h1))
            axw(OFS_HOLD, {25'h0, v | 7'h1});
            axr(OFS_STATUS, rd);
            `CHK(rd[14:8], v & (~v + 7'h1))
            axw(OFS_HOLD, 32'h0);
        end
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        op(3'h5, 1'h0, 1'h1, 32'hFE00_0010, 32'h0);
        stall <= 1'h1;
        op(3'h6, 1'h0, 1'h1, 32'h40, 32'h0);
        stall <= 1'h0;
        terr <= 1'h1;
        op(3'h3, 1'h1, 1'h1, 32'h80, 32'h1);
        terr <= 1'h0;
        axw(OFS_IMASK, 32'h2);
        axw(OFS_ISTAT, 32'h3);
        op(3'h4, 1'h0, 1'h1, 32'h0800_0000, 32'h0);
        `CHK(irq, 1'h0)
        op(3'h1, 1'h0, 1'h1, 32'h2000_0000, 32'h0);
        `CHK(irq, 1'h1)
        axw(OFS_ISTAT, 32'h3);
        axr(OFS_ISTAT, rd);
        `CHK(rd, 32'h0)
        `CHK(irq, 1'h0)
        axw(8'h40, 32'h0);
        axr(8'h40, rd);
        `CHK(rd, 32'h0)
        tally_and_finish();
    end
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
endmodule
